/* bus_timeout_params.svh */
`ifndef BUS_TIMEOUT_PARAMS_SVH
`define BUS_TIMEOUT_PARAMS_SVH

// ----------------------------------------
// Time base
// ----------------------------------------
`define MCLK_PERIOD_NS      4
`define USEC_NS             1000
`define USEC_CYCLES         (`USEC_NS / `MCLK_PERIOD_NS)
`define PRESCALE_W          8

// ----------------------------------------
// Limits in microseconds
// ----------------------------------------
`define LIMIT_W             9
`define LPB_LIMIT_0_US      9'h008
`define LPB_LIMIT_1_US      9'h040
`define LPB_LIMIT_2_US      9'h100
`define PROC_LIMIT_0_US     9'h008
`define PROC_LIMIT_1_US     9'h010
`define PROC_LIMIT_2_US     9'h020
`define PROC_LIMIT_3_US     9'h040

// ----------------------------------------
// Select codes and error strobe
// ----------------------------------------
`define LPB_SEL_INFINITE    2'h3
`define TEA_PULSE_CYCLES    3'h2
`define SYNC_STAGES         3

`endif

/* bus_timeout_pkg.sv */
package bus_timeout_pkg;

    typedef struct packed {
        logic       enable;
        logic [1:0] period_sel;
    } proc_ctrl_t;

    typedef struct packed {
        logic       enable;
        logic [1:0] limit_sel;
    } lpb_ctrl_t;

    // Bus pins, all active low except routing flags
    typedef struct packed {
        logic data_bus_busy_n;
        logic transfer_ack_n;
        logic transfer_error_ack_n;
        logic transfer_retry_n;
        logic access_to_lpb;
        logic lpb_access_n;
        logic lpb_ack_n;
        logic lpb_error_ack_n;
        logic lpb_vme_bound;
    } bus_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_COUNT = 2'b01,
        ST_DRIVE = 2'b10,
        ST_WAIT  = 2'b11
    } mon_state_t;

endpackage : bus_timeout_pkg

/* usec_timer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bus_timeout_params.svh"

module usec_timer (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                run,
    input  wire logic                clear,
    input  wire logic                usec_tick,
    input  wire logic [`LIMIT_W-1:0] limit_us,
    input  wire logic                infinite,
    output var  logic                expired_reg
);

    logic [`LIMIT_W-1:0] count_reg;

    // ----------------------------------------
    // Microsecond count
    // ----------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_reg <= 9'h000;
        end else if (clear || !run) begin
            count_reg <= 9'h000;
        end else if (usec_tick && count_reg != limit_us) begin
            count_reg <= count_reg + 9'h001;
        end
    end

    // Infinite limit never expires; first partial microsecond may be short
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            expired_reg <= 1'b0;
        end else begin
            expired_reg <= run && !clear && !infinite && (count_reg == limit_us);
        end
    end

endmodule : usec_timer
`default_nettype wire

/* bus_timeout_monitor.sv */
// Behaviour
// - Enabled processor timer starts on bus busy
// - Unterminated cycle at timeout gets error acknowledge
// - Processor timer idle for local peripheral accesses
// - Local bus overrun gets error acknowledge
// - Local limit: 8, 64, 256 us, infinite
// - Local timer ignores VMEbus bound cycles
//
`timescale 1ns/1ns
`default_nettype none
`include "bus_timeout_params.svh"

module bus_timeout_monitor
    import bus_timeout_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire proc_ctrl_t proc_bus_timer_control,
    input  wire lpb_ctrl_t  lpb_timer_control,
    input  wire bus_pins_t  pins_in,
    output var  logic       transfer_error_ack_n_o,
    output var  logic       transfer_error_ack_n_oe,
    output var  logic       lpb_error_ack_n_o,
    output var  logic       lpb_error_ack_n_oe,
    output var  logic       proc_timeout_pulse,
    output var  logic       lpb_timeout_pulse
);

    localparam int PIN_W = $bits(bus_pins_t);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic [`LIMIT_W-1:0] lpb_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    lpb_limit = `LPB_LIMIT_0_US;
            2'h1:    lpb_limit = `LPB_LIMIT_1_US;
            2'h2:    lpb_limit = `LPB_LIMIT_2_US;
            // Shortest limit here, so a lost infinite flag shows up fast
            default: lpb_limit = `LPB_LIMIT_0_US;
        endcase
    endfunction : lpb_limit

    function automatic logic [`LIMIT_W-1:0] proc_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    proc_limit = `PROC_LIMIT_0_US;
            2'h1:    proc_limit = `PROC_LIMIT_1_US;
            2'h2:    proc_limit = `PROC_LIMIT_2_US;
            default: proc_limit = `PROC_LIMIT_3_US;
        endcase
    endfunction : proc_limit

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Pins idle high except the routing flags, so reset to the idle pattern
    localparam bus_pins_t PINS_IDLE = '{
        data_bus_busy_n:      1'b1,
        transfer_ack_n:       1'b1,
        transfer_error_ack_n: 1'b1,
        transfer_retry_n:     1'b1,
        access_to_lpb:        1'b0,
        lpb_access_n:         1'b1,
        lpb_ack_n:            1'b1,
        lpb_error_ack_n:      1'b1,
        lpb_vme_bound:        1'b0
    };

    logic [PIN_W-1:0] sync1_reg;
    logic [PIN_W-1:0] sync2_reg;
    logic [PIN_W-1:0] sync3_reg;
    logic [PIN_W-1:0] filt_reg;
    bus_pins_t        pins;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_ff @(posedge mclk or posedge reset) begin
                if (reset) begin
                    sync1_reg[gi] <= PINS_IDLE[gi];
                    sync2_reg[gi] <= PINS_IDLE[gi];
                    sync3_reg[gi] <= PINS_IDLE[gi];
                    filt_reg[gi]  <= PINS_IDLE[gi];
                end else begin
                    sync1_reg[gi] <= pins_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    // Accept a change only once two stages agree
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        filt_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    assign pins = bus_pins_t'(filt_reg);

    // ----------------------------------------
    // Microsecond time base
    // ----------------------------------------
    logic [`PRESCALE_W-1:0] prescale_reg;
    logic                   usec_tick_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prescale_reg  <= 8'h00;
            usec_tick_reg <= 1'b0;
        end else if (prescale_reg == `PRESCALE_W'(`USEC_CYCLES - 1)) begin
            prescale_reg  <= 8'h00;
            usec_tick_reg <= 1'b1;
        end else begin
            prescale_reg  <= prescale_reg + 8'h01;
            usec_tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Processor bus timeout
    // ----------------------------------------
    mon_state_t proc_state_reg;
    logic [2:0] proc_pulse_reg;
    logic       proc_expired;
    logic       proc_busy;
    logic       proc_term;

    assign proc_busy = !pins.data_bus_busy_n;
    assign proc_term = !pins.transfer_ack_n || !pins.transfer_error_ack_n
                       || !pins.transfer_retry_n;

    usec_timer u_proc_timer (
        .mclk        (mclk),
        .reset       (reset),
        .run         (proc_state_reg == ST_COUNT),
        .clear       (proc_term || !proc_busy || pins.access_to_lpb),
        .usec_tick   (usec_tick_reg),
        .limit_us    (proc_limit(proc_bus_timer_control.period_sel)),
        .infinite    (1'b0),
        .expired_reg (proc_expired)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            proc_state_reg <= ST_IDLE;
            proc_pulse_reg <= 3'h0;
        end else begin
            case (proc_state_reg)
                ST_IDLE: begin
                    if (proc_bus_timer_control.enable && proc_busy
                        && !pins.access_to_lpb && !proc_term) begin
                        proc_state_reg <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (pins.access_to_lpb) begin
                        proc_state_reg <= ST_IDLE;
                    end else if (proc_term || !proc_busy
                                 || !proc_bus_timer_control.enable) begin
                        proc_state_reg <= ST_IDLE;
                    end else if (proc_expired) begin
                        proc_state_reg <= ST_DRIVE;
                        proc_pulse_reg <= `TEA_PULSE_CYCLES;
                    end
                end
                ST_DRIVE: begin
                    proc_pulse_reg <= proc_pulse_reg - 3'h1;
                    if (proc_pulse_reg == 3'h1) begin
                        proc_state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Hold off until the master drops busy, else we retrigger
                    if (!proc_busy) begin
                        proc_state_reg <= ST_IDLE;
                    end
                end
                default: proc_state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            transfer_error_ack_n_o  <= 1'b1;
            transfer_error_ack_n_oe <= 1'b0;
            proc_timeout_pulse      <= 1'b0;
        end else begin
            transfer_error_ack_n_o  <= 1'b0;
            transfer_error_ack_n_oe <= (proc_state_reg == ST_DRIVE);
            proc_timeout_pulse      <= (proc_state_reg == ST_COUNT) && proc_expired
                                       && !pins.access_to_lpb && !proc_term
                                       && proc_busy && proc_bus_timer_control.enable;
        end
    end

    // ----------------------------------------
    // Local peripheral bus timeout
    // ----------------------------------------
    mon_state_t lpb_state_reg;
    logic [2:0] lpb_pulse_reg;
    logic       lpb_expired;
    logic       lpb_busy;
    logic       lpb_term;

    assign lpb_busy = !pins.lpb_access_n;
    assign lpb_term = !pins.lpb_ack_n || !pins.lpb_error_ack_n;

    usec_timer u_lpb_timer (
        .mclk        (mclk),
        .reset       (reset),
        .run         (lpb_state_reg == ST_COUNT),
        .clear       (lpb_term || !lpb_busy || pins.lpb_vme_bound),
        .usec_tick   (usec_tick_reg),
        .limit_us    (lpb_limit(lpb_timer_control.limit_sel)),
        .infinite    (lpb_timer_control.limit_sel == `LPB_SEL_INFINITE),
        .expired_reg (lpb_expired)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lpb_state_reg <= ST_IDLE;
            lpb_pulse_reg <= 3'h0;
        end else begin
            case (lpb_state_reg)
                ST_IDLE: begin
                    if (lpb_timer_control.enable && lpb_busy
                        && !pins.lpb_vme_bound && !lpb_term) begin
                        lpb_state_reg <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (pins.lpb_vme_bound) begin
                        lpb_state_reg <= ST_IDLE;
                    end else if (lpb_term || !lpb_busy || !lpb_timer_control.enable) begin
                        lpb_state_reg <= ST_IDLE;
                    end else if (lpb_expired) begin
                        lpb_state_reg <= ST_DRIVE;
                        lpb_pulse_reg <= `TEA_PULSE_CYCLES;
                    end
                end
                ST_DRIVE: begin
                    lpb_pulse_reg <= lpb_pulse_reg - 3'h1;
                    if (lpb_pulse_reg == 3'h1) begin
                        lpb_state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!lpb_busy) begin
                        lpb_state_reg <= ST_IDLE;
                    end
                end
                default: lpb_state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lpb_error_ack_n_o  <= 1'b1;
            lpb_error_ack_n_oe <= 1'b0;
            lpb_timeout_pulse  <= 1'b0;
        end else begin
            lpb_error_ack_n_o  <= 1'b0;
            lpb_error_ack_n_oe <= (lpb_state_reg == ST_DRIVE);
            lpb_timeout_pulse  <= (lpb_state_reg == ST_COUNT) && lpb_expired
                                  && !pins.lpb_vme_bound && !lpb_term
                                  && lpb_busy && lpb_timer_control.enable;
        end
    end

endmodule : bus_timeout_monitor
`default_nettype wire

/* bus_timeout_monitor_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module bus_timeout_checker
    import bus_timeout_pkg::*;
(
    input wire logic       mclk,
    input wire logic       reset,
    input wire proc_ctrl_t proc_bus_timer_control,
    input wire lpb_ctrl_t  lpb_timer_control,
    input wire bus_pins_t  pins_in,
    input wire logic       transfer_error_ack_n_o,
    input wire logic       transfer_error_ack_n_oe,
    input wire logic       lpb_error_ack_n_o,
    input wire logic       lpb_error_ack_n_oe,
    input wire logic       proc_timeout_pulse,
    input wire logic       lpb_timeout_pulse
);
    // ----
    // Raw cycle age
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    logic [31:0] proc_cnt_reg;
    logic [31:0] lpb_cnt_reg;
    logic [31:0] proc_min;
    logic [31:0] lpb_min;
    // Lower bounds only: tick phase and pin sync blur the upper edge
    always_comb begin
        proc_min = ((32'h8 << proc_bus_timer_control.period_sel) - 32'h1) * 32'hfa;
        case (lpb_timer_control.limit_sel)
            2'h0: lpb_min = 32'h7 * 32'hfa;
            2'h1: lpb_min = 32'h3f * 32'hfa;
            2'h2: lpb_min = 32'hff * 32'hfa;
            default: lpb_min = 32'hffffffff;
        endcase
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            proc_cnt_reg <= '0;
        else if (!pins_in.data_bus_busy_n && proc_bus_timer_control.enable
                 && !pins_in.access_to_lpb && pins_in.transfer_ack_n
                 && pins_in.transfer_error_ack_n && pins_in.transfer_retry_n)
            proc_cnt_reg <= proc_cnt_reg + 32'h1;
        else
            proc_cnt_reg <= '0;
    end
    always_ff @(posedge mclk or posedge reset) begin
        if (reset)
            lpb_cnt_reg <= '0;
        else if (!pins_in.lpb_access_n && lpb_timer_control.enable
                 && !pins_in.lpb_vme_bound && pins_in.lpb_ack_n
                 && pins_in.lpb_error_ack_n)
            lpb_cnt_reg <= lpb_cnt_reg + 32'h1;
        else
            lpb_cnt_reg <= '0;
    end
    sequence s_strobe(logic oe);
        oe [*2] ##1 !oe;
    endsequence
    property p_proc_age;   proc_timeout_pulse |-> proc_cnt_reg >= proc_min; endproperty
    property p_proc_strobe; proc_timeout_pulse |=> s_strobe(transfer_error_ack_n_oe); endproperty
    property p_proc_low;   transfer_error_ack_n_oe |-> !transfer_error_ack_n_o; endproperty
    property p_proc_cause; $rose(transfer_error_ack_n_oe) |-> $past(proc_timeout_pulse); endproperty
    property p_proc_once;  proc_timeout_pulse |=> !proc_timeout_pulse [*4]; endproperty
    property p_lpb_age;    lpb_timeout_pulse |-> lpb_cnt_reg >= lpb_min; endproperty
    property p_lpb_strobe; lpb_timeout_pulse |=> s_strobe(lpb_error_ack_n_oe); endproperty
    property p_lpb_low;    lpb_error_ack_n_oe |-> !lpb_error_ack_n_o; endproperty
    a_proc_age: assert property (p_proc_age)
        else $error("processor timeout too early");
    a_proc_strobe: assert property (p_proc_strobe)
        else $error("processor error strobe wrong");
    a_proc_low: assert property (p_proc_low)
        else $error("processor error not driven low");
    a_proc_cause: assert property (p_proc_cause)
        else $error("processor error without timeout");
    a_proc_once: assert property (p_proc_once)
        else $error("processor timeout repeated");
    a_lpb_age: assert property (p_lpb_age)
        else $error("local timeout too early");
    a_lpb_strobe: assert property (p_lpb_strobe)
        else $error("local error strobe wrong");
    a_lpb_low: assert property (p_lpb_low)
        else $error("local error not driven low");
endmodule : bus_timeout_checker
bind bus_timeout_monitor bus_timeout_checker i_checker (.mclk(mclk), .reset(reset),
    .proc_bus_timer_control(proc_bus_timer_control), .lpb_timer_control(lpb_timer_control),
    .pins_in(pins_in), .transfer_error_ack_n_o(transfer_error_ack_n_o),
    .transfer_error_ack_n_oe(transfer_error_ack_n_oe), .lpb_error_ack_n_o(lpb_error_ack_n_o),
    .lpb_error_ack_n_oe(lpb_error_ack_n_oe), .proc_timeout_pulse(proc_timeout_pulse),
    .lpb_timeout_pulse(lpb_timeout_pulse));
`default_nettype wire

/* bus_agent.sv */
`timescale 1ns/1ns
`default_nettype none
module bus_agent
    import bus_timeout_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic        local_bus,
    input  wire logic        route_lpb,
    input  wire logic        vme,
    input  wire logic [1:0]  term,
    input  wire logic [31:0] delay,
    input  wire logic        proc_err_n,
    input  wire logic        lpb_err_n,
    output var  logic        active,
    output var  bus_pins_t   pins
);
    // ----
    // Master and slave
    // ----
    logic [31:0] cnt;
    logic        acking;
    logic        p_on;
    logic        l_on;
    // Delay zero never answers; released lines idle high on pull-ups
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            active <= 1'b0;
            acking <= 1'b0;
            cnt    <= '0;
        end else if (!active) begin
            active <= start;
            cnt    <= '0;
        end else if (acking || !(local_bus ? lpb_err_n : proc_err_n)) begin
            active <= 1'b0;
            acking <= 1'b0;
        end else begin
            cnt    <= cnt + 32'h1;
            acking <= (delay != '0) && (cnt == delay);
        end
    end
    assign p_on = active && !local_bus;
    assign l_on = active && local_bus;
    always_comb begin
        pins.data_bus_busy_n      = !p_on;
        pins.transfer_ack_n       = !(p_on && acking && term == 2'h0);
        pins.transfer_retry_n     = !(p_on && acking && term == 2'h1);
        pins.transfer_error_ack_n = proc_err_n && !(p_on && acking && term == 2'h2);
        pins.access_to_lpb        = p_on && route_lpb;
        pins.lpb_access_n         = !l_on;
        pins.lpb_ack_n            = !(l_on && acking);
        pins.lpb_error_ack_n      = lpb_err_n;
        pins.lpb_vme_bound        = l_on && vme;
    end
endmodule : bus_agent
`default_nettype wire

/* bus_timeout_monitor_test.sv */
`timescale 1ns/1ns
`default_nettype none
module bus_timeout_monitor_test
    import bus_timeout_pkg::*;
;
    // ----
    // Bench
    // ----
    logic        mclk, reset, start, local_bus, route_lpb, vme, active;
    logic        p_o, p_oe, l_o, l_oe, p_pulse, l_pulse, p_wire, l_wire;
    logic [1:0]  term;
    logic [31:0] delay;
    proc_ctrl_t  pctl;
    lpb_ctrl_t   lctl;
    bus_pins_t   pins;
    int          n_mismatch, tests_run;
    assign p_wire = p_oe ? p_o : 1'b1;
    assign l_wire = l_oe ? l_o : 1'b1;
    bus_timeout_monitor i_dut (.mclk(mclk), .reset(reset), .proc_bus_timer_control(pctl),
        .lpb_timer_control(lctl), .pins_in(pins), .transfer_error_ack_n_o(p_o),
        .transfer_error_ack_n_oe(p_oe), .lpb_error_ack_n_o(l_o), .lpb_error_ack_n_oe(l_oe),
        .proc_timeout_pulse(p_pulse), .lpb_timeout_pulse(l_pulse));
    bus_agent i_agent (.mclk(mclk), .reset(reset), .start(start), .local_bus(local_bus),
        .route_lpb(route_lpb), .vme(vme), .term(term), .delay(delay), .proc_err_n(p_wire),
        .lpb_err_n(l_wire), .active(active), .pins(pins));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    // Zero us means no timeout may come within win cycles
    task run_cycle(input logic loc, rt, vm, input logic [1:0] tm, input int dl, us, win);
        int hit, strobe, n;
        @(negedge mclk);
        {local_bus, route_lpb, vme, term} = {loc, rt, vm, tm};
        delay = dl;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        hit = -1;
        strobe = 0;
        if (us > 0)
            win = us * 250 + 40;
        for (n = 0; n < win; n++) begin
            @(negedge mclk);
            if ((loc ? l_pulse : p_pulse) === 1'b1 && hit < 0)
                hit = n;
            // Count the wire itself so a wrong driven level shows too
            if ((loc ? l_wire : p_wire) === 1'b0)
                strobe++;
        end
        check(hit < 0 ? us == 0 : us > 0 && hit >= (us - 1) * 250
              && hit <= us * 250 + 20, 1);
        check(strobe, us > 0 ? 2 : 0);
        for (n = 0; n < 300 && active; n++)
            @(negedge mclk);
        if (active !== 1'b0) begin
            check(active, 1'b0);
            finish_test;
        end
        repeat (8) @(negedge mclk);
    endtask : run_cycle
    task s_proc_terms;
        for (int t = 0; t < 3; t++)
            run_cycle(0, 0, 0, t[1:0], 1700, 0, 1750);
        run_cycle(0, 0, 0, 2'h0, 0, 8, 0);
    endtask : s_proc_terms
    task s_proc_routed;
        run_cycle(0, 1, 0, 2'h0, 2100, 0, 2150);
    endtask : s_proc_routed
    task s_proc_disabled;
        pctl = 3'h0;
        run_cycle(0, 0, 0, 2'h0, 2100, 0, 2150);
        pctl = 3'h4;
    endtask : s_proc_disabled
    task s_lpb_limits;
        for (int s = 0; s < 3; s++) begin
            lctl = {1'b1, s[1:0]};
            run_cycle(1, 0, 0, 2'h0, 0, s == 0 ? 8 : s == 1 ? 64 : 256, 0);
        end
    endtask : s_lpb_limits
    task s_lpb_exempt;
        lctl = 3'h4;
        run_cycle(1, 0, 1, 2'h0, 2100, 0, 2150);
        lctl = 3'h7;
        run_cycle(1, 0, 0, 2'h0, 2100, 0, 2150);
    endtask : s_lpb_exempt
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        reset = 1'b1;
        {start, local_bus, route_lpb, vme, term, delay} = '0;
        pctl = 3'h4;
        lctl = 3'h4;
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        s_proc_terms;
        s_proc_routed;
        s_proc_disabled;
        s_lpb_limits;
        s_lpb_exempt;
        finish_test;
    end
endmodule : bus_timeout_monitor_test
`default_nettype wire
